/* verilog/ttu_timer_unit.sv */
// Triple 16-bit timer: register access, control and input conditioning
`timescale 1ns/100ps
module ttu_timer_unit (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  // Processor bus
  input  wire logic       chipSel,
  input  wire logic       readNotWrite,
  input  wire logic [2:0] selectLine,
  input  wire logic [7:0] dataIn,
  output logic      [7:0] dataOut,
  output logic            dataOe,
  // Interrupt request, open drain
  output logic            irqOut_b,
  output logic            irqOe,
  // Timer pins
  input  wire logic       hardwareClearIn_b,
  input  wire logic [2:0] extClock_b,
  input  wire logic [2:0] holdOff_b,
  output logic      [2:0] waveformOut
);
  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [7:0]  ctrl_reg [3];
  logic [15:0] latch_reg [3];
  logic [15:0] count_reg [3];
  logic [7:0]  highBuf_reg;
  logic [7:0]  lowBuf_reg;
  logic [2:0]  flag_reg;
  logic [2:0]  armed_reg;
  logic [2:0]  wave_reg;
  logic [2:0]  shotDone_reg;
  localparam int PRESCALE_BITS_L = ttu_pkg::PRESCALE_BITS;
  logic [PRESCALE_BITS_L-1:0] preCnt_reg;

  logic [6:0]  syncLevel;
  logic [6:0]  syncFall;
  logic        preLevel;
  logic        preFall;
  logic        writeStb;
  logic        readStb;
  logic        clrActive;
  logic        resetCond;
  logic        composite;
  logic [1:0]  selTimer;
  logic [2:0]  latchWr;
  logic [2:0]  cntRead;
  logic [2:0]  srcEvent;
  logic [2:0]  clkEvent;
  logic [2:0]  gateLow;
  logic [2:0]  gateFall;
  logic [2:0]  initReq;
  logic [2:0]  timeout;
  logic [15:0] count_next [3];
  logic [15:0] latch_next [3];

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Mode from bits 3 and 5
  function automatic ttu_pkg::ttu_mode_t modeOf(input logic [7:0] c);
    modeOf = ttu_pkg::ttu_mode_t'({c[ttu_pkg::BIT_MODE_A], c[ttu_pkg::BIT_MODE_C]});
  endfunction : modeOf

  // One counting step; bit 16 flags the time-out
  function automatic logic [16:0] tick(input logic [15:0] c, input logic [15:0] l,
                                       input logic dual);
    tick = {1'b0, c - 16'h0001};
    if (!dual) begin
      if (c == 16'h0000) tick = {1'b1, l};
    end else if (c[7:0] == 8'h00) begin
      if (c[15:8] == 8'h00) tick = {1'b1, l};
      else tick = {1'b0, c[15:8] - 8'h01, l[7:0]};
    end else begin
      tick = {1'b0, c[15:8], c[7:0] - 8'h01};
    end
  endfunction : tick

  // ----------------------------------------------------------------
  // Input conditioning
  // ----------------------------------------------------------------
  // Clear, hold-off and clock pins share one synchroniser
  ttu_input_sync #(
    .WIDTH  (7),
    .STAGES (ttu_pkg::SYNC_DEPTH)
  ) u_pinSync (
    .clk       (clk),
    .rst_b     (rst_b),
    .rawIn     ({hardwareClearIn_b, holdOff_b, extClock_b}),
    .levelOut  (syncLevel),
    .fallPulse (syncFall)
  );

  // Prescaler output recognised like an external clock
  ttu_input_sync #(
    .WIDTH  (1),
    .STAGES (ttu_pkg::SYNC_DEPTH)
  ) u_preSync (
    .clk       (clk),
    .rst_b     (rst_b),
    .rawIn     (preCnt_reg[PRESCALE_BITS_L-1]),
    .levelOut  (preLevel),
    .fallPulse (preFall)
  );

  // ----------------------------------------------------------------
  // Decode and event logic
  // ----------------------------------------------------------------
  assign writeStb  = chipSel & ~readNotWrite;
  assign readStb   = chipSel & readNotWrite;
  assign clrActive = ~syncLevel[6];
  assign resetCond = clrActive | ctrl_reg[0][ttu_pkg::BIT_ADDR_SEL];
  assign selTimer  = selectLine[2:1] - 2'd1;
  assign gateLow   = ~syncLevel[5:3];
  assign gateFall  = syncFall[5:3];

  // Per-timer strobes and clock selection
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      latchWr[i]  = writeStb && selectLine[0] && selTimer == 2'(i);
      cntRead[i]  = readStb && !selectLine[0] && selectLine[2:1] != 2'd0 && selTimer == 2'(i);
      srcEvent[i] = ctrl_reg[i][ttu_pkg::BIT_CLK_SRC] ? 1'b1 : syncFall[i];
      clkEvent[i] = srcEvent[i];
      latch_next[i] = {highBuf_reg, dataIn};
      initReq[i]  = gateFall[i] || (latchWr[i] && !ctrl_reg[i][ttu_pkg::BIT_MODE_B]);
    end
    if (ctrl_reg[2][ttu_pkg::BIT_ADDR_SEL]) clkEvent[2] = preFall;
  end

  // Next count; hold-off gates the counter itself
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      logic [16:0] t;
      t = tick(count_reg[i], latch_reg[i], ctrl_reg[i][ttu_pkg::BIT_WIDTH]);
      timeout[i]    = 1'b0;
      count_next[i] = count_reg[i];
      if (initReq[i]) begin
        count_next[i] = latchWr[i] ? latch_next[i] : latch_reg[i];
      end else if (clkEvent[i] && gateLow[i]) begin
        count_next[i] = t[15:0];
        timeout[i]    = t[16];
      end
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  // Internal reset bit never touches these
  always_ff @(posedge clk) begin
    if (!rst_b || clrActive) begin
      ctrl_reg[0] <= ttu_pkg::CTRL1_RESET;
      ctrl_reg[1] <= ttu_pkg::CTRL_RESET;
      ctrl_reg[2] <= ttu_pkg::CTRL_RESET;
    end else if (writeStb) begin
      if (selectLine == ttu_pkg::SEL_CTRL2) ctrl_reg[1] <= dataIn;
      if (selectLine == ttu_pkg::SEL_CTRL13) begin
        if (ctrl_reg[1][ttu_pkg::BIT_ADDR_SEL]) ctrl_reg[0] <= dataIn;
        else ctrl_reg[2] <= dataIn;
      end
    end
  end

  // Holding buffer and latches
  always_ff @(posedge clk) begin
    if (!rst_b || clrActive) begin
      highBuf_reg <= 8'h00;
      for (int i = 0; i < 3; i++) latch_reg[i] <= ttu_pkg::LATCH_RESET;
    end else if (writeStb) begin
      if (!selectLine[0] && selectLine[2:1] != 2'd0) highBuf_reg <= dataIn;
      for (int i = 0; i < 3; i++) begin
        if (latchWr[i]) latch_reg[i] <= latch_next[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // Counters and prescaler
  // ----------------------------------------------------------------
  // Preset from latches while the internal reset bit stands; external reset and hardware clear load LATCH_RESET
  always_ff @(posedge clk) begin
    for (int i = 0; i < 3; i++) begin
      if (!rst_b || clrActive) count_reg[i] <= ttu_pkg::LATCH_RESET;
      else if (resetCond) count_reg[i] <= latch_reg[i];
      else count_reg[i] <= count_next[i];
    end
  end

  // Divide-by-8 on timer 3 clock source
  always_ff @(posedge clk) begin
    if (!rst_b || resetCond) preCnt_reg <= '0;
    else if (srcEvent[2]) preCnt_reg <= preCnt_reg + PRESCALE_BITS_L'(1);
  end

  // ----------------------------------------------------------------
  // Waveform generation
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_b || resetCond) begin
      wave_reg     <= '0;
      shotDone_reg <= '0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        case (modeOf(ctrl_reg[i]))
          ttu_pkg::TTU_CONT: begin
            if (initReq[i]) wave_reg[i] <= 1'b0;
            else if (ctrl_reg[i][ttu_pkg::BIT_WIDTH])
              wave_reg[i] <= !timeout[i] && count_next[i][15:8] == 8'h00;
            else if (timeout[i]) wave_reg[i] <= !wave_reg[i];
          end
          ttu_pkg::TTU_SINGLE: begin
            if (initReq[i]) begin
              wave_reg[i]     <= !ctrl_reg[i][ttu_pkg::BIT_WIDTH];
              shotDone_reg[i] <= 1'b0;
            end else if (timeout[i]) begin
              wave_reg[i]     <= 1'b0;
              shotDone_reg[i] <= 1'b1;
            end else if (ctrl_reg[i][ttu_pkg::BIT_WIDTH] && !shotDone_reg[i]) begin
              wave_reg[i] <= count_next[i][15:8] == 8'h00;
            end
          end
          ttu_pkg::TTU_FREQ, ttu_pkg::TTU_PULSE: begin
            if (timeout[i]) wave_reg[i] <= !wave_reg[i];
          end
          default: wave_reg[i] <= 1'b0;
        endcase
      end
    end
  end

  // Output enable gate acts at once
  always_comb begin
    for (int i = 0; i < 3; i++)
      waveformOut[i] = wave_reg[i] & ctrl_reg[i][ttu_pkg::BIT_OUT_EN];
  end

  // ----------------------------------------------------------------
  // Interrupt flags
  // ----------------------------------------------------------------
  // Time-out sets; in the same cycle set beats a latch-write or read clear, and reset beats set
  always_ff @(posedge clk) begin
    if (!rst_b || resetCond) begin
      flag_reg  <= '0;
      armed_reg <= '0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (timeout[i]) begin
          flag_reg[i] <= 1'b1;
        end else if (initReq[i] || latchWr[i] || (cntRead[i] && armed_reg[i])) begin
          flag_reg[i]  <= 1'b0;
          armed_reg[i] <= 1'b0;
        end else if (readStb && selectLine == ttu_pkg::SEL_CTRL2 && flag_reg[i]) begin
          armed_reg[i] <= 1'b1;
        end
      end
    end
  end

  // Composite flag and open-drain request
  always_comb begin
    composite = 1'b0;
    for (int i = 0; i < 3; i++)
      composite = composite | (flag_reg[i] & ctrl_reg[i][ttu_pkg::BIT_IRQ_EN]);
  end
  assign irqOut_b = 1'b0;
  assign irqOe    = composite;

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // Registered read data; counter read captures low byte
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      dataOut    <= 8'h00;
      dataOe     <= 1'b0;
      lowBuf_reg <= 8'h00;
    end else begin
      dataOe <= readStb;
      if (readStb) begin
        if (selectLine == ttu_pkg::SEL_CTRL13) dataOut <= 8'h00;
        else if (selectLine == ttu_pkg::SEL_CTRL2)
          dataOut <= {composite, 4'h0, flag_reg};
        else if (selectLine[0]) dataOut <= lowBuf_reg;
        else begin
          dataOut    <= count_reg[selTimer][15:8];
          lowBuf_reg <= count_reg[selTimer][7:0];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_extFall0;
    $fell(extClock_b[0]) ##1 !extClock_b[0] [*2];
  endsequence
  property p_extDelay;
    @(posedge clk) disable iff (!rst_b) s_extFall0 |-> ##1 syncFall[0];
  endproperty
  a_extDelay: assert property (p_extDelay) else $error("clock edge not seen on fourth pulse");
  property p_ctrl2Write;
    @(posedge clk) disable iff (!rst_b || clrActive)
      writeStb && selectLine == ttu_pkg::SEL_CTRL2 |=> ctrl_reg[1] == $past(dataIn);
  endproperty
  a_ctrl2Write: assert property (p_ctrl2Write) else $error("control 2 write lost");
  property p_ctrl13Route;
    @(posedge clk) disable iff (!rst_b || clrActive)
      writeStb && selectLine == ttu_pkg::SEL_CTRL13 && !ctrl_reg[1][0] |=> ctrl_reg[2] == $past(dataIn)
        && $stable(ctrl_reg[0]);
  endproperty
  a_ctrl13Route: assert property (p_ctrl13Route) else $error("shared control write misrouted");
  property p_latchWrite;
    @(posedge clk) disable iff (!rst_b || clrActive)
      latchWr[0] |=> latch_reg[0] == {$past(highBuf_reg), $past(dataIn)};
  endproperty
  a_latchWrite: assert property (p_latchWrite) else $error("latch write bytes wrong");
  property p_statusRead;
    @(posedge clk) disable iff (!rst_b)
      readStb && selectLine == ttu_pkg::SEL_CTRL2 |=> dataOe && dataOut[6:3] == 4'h0
        && dataOut[2:0] == $past(flag_reg) && dataOut[7] == $past(composite);
  endproperty
  a_statusRead: assert property (p_statusRead) else $error("status read wrong");
  property p_lowCapture;
    @(posedge clk) disable iff (!rst_b)
      cntRead[1] |=> lowBuf_reg == $past(count_reg[1][7:0]) && dataOut == $past(count_reg[1][15:8]);
  endproperty
  a_lowCapture: assert property (p_lowCapture) else $error("counter read not coherent");
  property p_outMask;
    @(posedge clk) disable iff (!rst_b) $fell(ctrl_reg[0][ttu_pkg::BIT_OUT_EN]) |-> waveformOut[0] == 1'b0;
  endproperty
  a_outMask: assert property (p_outMask) else $error("masked output not low");
  property p_intReset;
    @(posedge clk) disable iff (!rst_b)
      ctrl_reg[0][0] && !clrActive |=> flag_reg == 3'b000 && waveformOut == 3'b000
        && count_reg[1] == $past(latch_reg[1]);
  endproperty
  a_intReset: assert property (p_intReset) else $error("internal reset not holding");
  property p_irqLine;
    @(posedge clk) disable iff (!rst_b)
      irqOe |-> !irqOut_b && !$past(resetCond) && |(flag_reg & {ctrl_reg[2][6], ctrl_reg[1][6], ctrl_reg[0][6]});
  endproperty
  a_irqLine: assert property (p_irqLine) else $error("request without enabled flag");
  property p_flagClear;
    @(posedge clk) disable iff (!rst_b)
      cntRead[0] && armed_reg[0] && !timeout[0] |=> !flag_reg[0];
  endproperty
  a_flagClear: assert property (p_flagClear) else $error("flag survived armed read");
  property p_holdOff;
    @(posedge clk) disable iff (!rst_b)
      !gateLow[0] && !initReq[0] && !resetCond |=> $stable(count_reg[0]);
  endproperty
  a_holdOff: assert property (p_holdOff) else $error("counter moved while held off");
endmodule : ttu_timer_unit

/* verilog/ttu_pkg.sv */
// Constants and types shared by the triple timer unit
package ttu_pkg;
  // ----------------------------------------------------------------
  // Select decode
  // ----------------------------------------------------------------
  localparam logic [2:0] SEL_CTRL13 = 3'h0;
  localparam logic [2:0] SEL_CTRL2  = 3'h1;
  // Control register bit positions
  localparam int BIT_ADDR_SEL  = 0;
  localparam int BIT_CLK_SRC   = 1;
  localparam int BIT_WIDTH     = 2;
  localparam int BIT_MODE_A    = 3;
  localparam int BIT_MODE_B    = 4;
  localparam int BIT_MODE_C    = 5;
  localparam int BIT_IRQ_EN    = 6;
  localparam int BIT_OUT_EN    = 7;
  localparam int BIT_COMPOSITE = 7;
  // ----------------------------------------------------------------
  // Reset values and sizes
  // ----------------------------------------------------------------
  localparam logic [7:0]  CTRL1_RESET  = 8'h01;
  localparam logic [7:0]  CTRL_RESET   = 8'h00;
  localparam logic [15:0] LATCH_RESET  = 16'hFFFF;
  localparam int          PRESCALE_BITS = 3;
  localparam int          SYNC_DEPTH    = 3;
  // Operating modes from bits 3 and 5
  typedef enum logic [1:0] {
    TTU_CONT   = 2'b00,
    TTU_SINGLE = 2'b01,
    TTU_FREQ   = 2'b10,
    TTU_PULSE  = 2'b11
  } ttu_mode_t;
endpackage : ttu_pkg

/* verilog/ttu_input_sync.sv */
// Free-running synchroniser with recognised level and falling pulse
`timescale 1ns/100ps
module ttu_input_sync #(
  parameter int WIDTH  = 1,
  parameter int STAGES = 3
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_b,
  // Raw and recognised inputs
  input  wire logic [WIDTH-1:0] rawIn,
  output logic      [WIDTH-1:0] levelOut,
  output logic      [WIDTH-1:0] fallPulse
);
  if (STAGES < 2) begin : g_bad
    $error("ttu_input_sync needs at least two stages");
  end

  logic [WIDTH-1:0] stage [STAGES];

  // Shift chain; first stage feeds the second, and also the outputs when STAGES is 2
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      for (int s = 0; s < STAGES; s++) stage[s] <= '1;
    end else begin
      stage[0] <= rawIn;
      for (int s = 1; s < STAGES; s++) stage[s] <= stage[s-1];
    end
  end

  // Registered level and falling edge, seen on the next pulse
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      levelOut  <= '1;
      fallPulse <= '0;
    end else begin
      levelOut  <= stage[STAGES-2];
      fallPulse <= stage[STAGES-1] & ~stage[STAGES-2];
    end
  end
endmodule : ttu_input_sync

/* dv/ttu_cpu_model.sv */
// Processor bus master model for the timer unit registers
`timescale 1ns/100ps
module ttu_cpu_model (
  // Clock
  input  wire logic       clk,
  // Register bus
  output logic            chipSel,
  output logic            readNotWrite,
  output logic      [2:0] selectLine,
  output logic      [7:0] dataIn,
  input  wire logic [7:0] dataOut,
  input  wire logic       dataOe
);
  // Idle bus at time zero
  initial begin
    chipSel      = 1'b0;
    readNotWrite = 1'b1;
    selectLine   = 3'h0;
    dataIn       = 8'h00;
  end
  // One access, prompt or slow, held for one cycle
  task automatic access(input logic rnw, input logic [2:0] sel, input logic [7:0] wd,
                        output logic [7:0] rd, output logic oe);
    repeat ($urandom_range(1, 3)) @(negedge clk);
    chipSel      = 1'b1;
    readNotWrite = rnw;
    selectLine   = sel;
    dataIn       = wd;
    @(negedge clk);
    rd           = dataOut;
    oe           = dataOe;
    chipSel      = 1'b0;
    readNotWrite = ~rnw; // Released lines keep no stale value
    selectLine   = ~sel;
    dataIn       = ~wd;
  endtask : access
endmodule : ttu_cpu_model

/* dv/tb_triple_timer_control_and_inputs.sv */
// Self-checking bench for the triple timer unit
`timescale 1ns/100ps
module tb_triple_timer_control_and_inputs;
  // ----------------------------------------
  // Signals and model state
  // ----------------------------------------
  logic       clk;
  logic       rst_b;
  logic       chipSel;
  logic       readNotWrite;
  logic [2:0] selectLine;
  logic [7:0] dataIn;
  logic [7:0] dataOut;
  logic       dataOe;
  logic       irqOut_b;
  logic       irqOe;
  logic       irqWire;
  logic       hardwareClearIn_b;
  logic [2:0] extClock_b;
  logic [2:0] holdOff_b;
  logic [2:0] waveformOut;
  logic [2:0] prevWave;
  logic [7:0] rdv;
  logic [7:0] hi;
  logic [7:0] lo;
  logic       oe;
  int         errorCnt;
  int         checkCount;
  int         latch [3];
  int         period [3];
  int         since [3];
  int         expPer;
  int         expQ [$];

  // Pull-up on the shared interrupt line
  assign irqWire = irqOe ? irqOut_b : 1'b1;

  // Clock at 20 MHz
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Design and bus master
  ttu_timer_unit u_ttu_timer_unit (
    .clk(clk), .rst_b(rst_b), .chipSel(chipSel), .readNotWrite(readNotWrite),
    .selectLine(selectLine), .dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe),
    .irqOut_b(irqOut_b), .irqOe(irqOe), .hardwareClearIn_b(hardwareClearIn_b),
    .extClock_b(extClock_b), .holdOff_b(holdOff_b), .waveformOut(waveformOut)
  );
  ttu_cpu_model u_ttu_cpu_model (
    .clk(clk), .chipSel(chipSel), .readNotWrite(readNotWrite), .selectLine(selectLine),
    .dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe)
  );

  // Cycles between rising edges of each waveform output
  always @(posedge clk) begin
    for (int t = 0; t < 3; t++) begin
      since[t]++;
      if (waveformOut[t] === 1'b1 && prevWave[t] === 1'b0) begin
        period[t] = since[t];
        since[t]  = 0;
      end
    end
    prevWave = waveformOut;
  end

  // ----------------------------------------
  // Checking and bus tasks
  // ----------------------------------------
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checkCount++;
    if (seen !== exp) begin
      errorCnt++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [2:0] sel, input logic [7:0] d);
    u_ttu_cpu_model.access(1'b0, sel, d, rdv, oe);
  endtask : wr

  task automatic rd(input logic [2:0] sel, input logic [7:0] exp);
    u_ttu_cpu_model.access(1'b1, sel, 8'h00, rdv, oe);
    check("read data", 16'(rdv), 16'(exp));
    check("read strobe", 16'(oe), 16'h0001);
  endtask : rd

  // Counter high byte, then the captured low byte
  task automatic rdCnt(input int t, input logic [15:0] v);
    rd(3'(2 * t + 2), v[15:8]);
    rd(3'(2 * t + 3), v[7:0]);
  endtask : rdCnt

  task automatic completeRun;
    $display("checks %0d errors %0d", checkCount, errorCnt);
    if (errorCnt == 0 && checkCount > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : completeRun

  // Watchdog well beyond the expected run
  initial begin
    repeat (20000) @(posedge clk);
    errorCnt++;
    completeRun();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(65473));
    rst_b             = 1'b0;
    hardwareClearIn_b = 1'b1;
    extClock_b        = 3'h7;
    holdOff_b         = 3'h0;
    repeat (20) @(negedge clk);
    rst_b = 1'b1;
    rd(3'h1, 8'h00);
    rd(3'h0, 8'h00);
    // Control 3, then 2, then 1 with the timers still preset
    wr(3'h0, 8'h83);
    wr(3'h1, 8'h87);
    wr(3'h0, 8'hC3);
    latch[0] = $urandom_range(5, 40);
    latch[1] = ($urandom_range(1, 4) << 8) | $urandom_range(2, 9);
    latch[2] = $urandom_range(2, 10);
    for (int t = 0; t < 3; t++) begin
      wr(3'(2 * t + 2), 8'(latch[t] >> 8));
      wr(3'(2 * t + 3), 8'(latch[t]));
      rdCnt(t, 16'(latch[t]));
    end
    // Release the timers and measure each waveform
    wr(3'h0, 8'hC2);
    repeat (600) @(negedge clk);
    for (int t = 0; t < 3; t++) begin
      expPer = 2 * (latch[t] + 1);
      if (t == 1)
        expPer = ((latch[1] & 255) + 1) * ((latch[1] >> 8) + 1);
      if (t == 2)
        expPer = 8 * expPer;
      expQ.push_back(expPer);
      check("period", 16'(period[t]), 16'(expQ.pop_front()));
    end
    // Output enable cleared just after the output rises
    for (int i = 0; i < 200 && waveformOut[0] !== 1'b0; i++) @(negedge clk);
    for (int i = 0; i < 200 && waveformOut[0] !== 1'b1; i++) @(negedge clk);
    check("wave on", 16'(waveformOut[0]), 16'h0001);
    wr(3'h0, 8'h42);
    check("wave off", 16'(waveformOut[0]), 16'h0000);
    repeat (100) @(negedge clk);
    check("wave held", 16'(waveformOut[0]), 16'h0000);
    // Freeze all timers, then flag arming and clearing
    holdOff_b = 3'h7;
    repeat (6) @(negedge clk);
    rd(3'h1, 8'h87);
    check("irq line", 16'(irqWire), 16'h0000);
    for (int t = 0; t < 3; t++) begin
      u_ttu_cpu_model.access(1'b1, 3'(2 * t + 2), 8'h00, hi, oe);
      u_ttu_cpu_model.access(1'b1, 3'(2 * t + 3), 8'h00, lo, oe);
      repeat (10) @(negedge clk);
      rdCnt(t, {hi, lo});
      if (t == 0)
        rd(3'h1, 8'h06);
    end
    rd(3'h1, 8'h00);
    check("irq idle", 16'(irqWire), 16'h0001);
    // External clock on timer 1
    wr(3'h0, 8'h00);
    holdOff_b[0] = 1'b0;
    repeat (6) @(negedge clk);
    rdCnt(0, 16'(latch[0]));
    repeat (3) begin
      extClock_b[0] = 1'b0;
      repeat (3) @(negedge clk);
      extClock_b[0] = 1'b1;
      repeat (3) @(negedge clk);
    end
    repeat (6) @(negedge clk);
    rdCnt(0, 16'(latch[0] - 3));
    // Hardware clear presets latches and counters
    hardwareClearIn_b = 1'b0;
    repeat (6) @(negedge clk);
    hardwareClearIn_b = 1'b1;
    repeat (6) @(negedge clk);
    rd(3'h1, 8'h00);
    rdCnt(0, 16'hFFFF);
    completeRun();
  end
endmodule : tb_triple_timer_control_and_inputs
